// *** core/hfds_pkg.sv ***
// constants, codes and carrier types of the hub full-speed descriptor source
package hfds_pkg;

    // ==========================================================
    // descriptor type codes
    localparam logic [7:0] HFDS_TYPE_DEVICE = 8'h01;
    localparam logic [7:0] HFDS_TYPE_IFACE = 8'h04;
    localparam logic [7:0] HFDS_TYPE_ENDPT = 8'h05;
    localparam logic [7:0] HFDS_TYPE_QUAL = 8'h06;

    // ==========================================================
    // descriptor lengths in bytes
    localparam logic [4:0] HFDS_LEN_DEVICE = 5'h12;
    localparam logic [4:0] HFDS_LEN_QUAL = 5'h0A;
    localparam logic [4:0] HFDS_LEN_IFACE = 5'h09;
    localparam logic [4:0] HFDS_LEN_ENDPT = 5'h07;

    // ==========================================================
    // field values
    localparam logic [15:0] HFDS_USB_REL = 16'h0200;
    localparam logic [7:0] HFDS_CLASS_HUB = 8'h09;
    localparam logic [7:0] HFDS_SUBCLASS = 8'h00;
    localparam logic [7:0] HFDS_PROTO_NONE = 8'h00;
    localparam logic [7:0] HFDS_PROTO_ONE_TT = 8'h01;
    localparam logic [7:0] HFDS_PROTO_PER_PORT = 8'h02;
    localparam logic [7:0] HFDS_MPS0 = 8'h40;
    localparam logic [7:0] HFDS_NUM_CFG = 8'h01;
    localparam logic [7:0] HFDS_RESERVED = 8'h00;
    localparam logic [7:0] HFDS_IF_NUM = 8'h00;
    localparam logic [7:0] HFDS_IF_ALT = 8'h00;
    localparam logic [7:0] HFDS_IF_NUM_EP = 8'h01;
    localparam logic [7:0] HFDS_STR_NONE = 8'h00;
    localparam logic [7:0] HFDS_STR_MANUF = 8'h01;
    localparam logic [7:0] HFDS_STR_PROD = 8'h02;
    localparam logic [7:0] HFDS_STR_SERIAL = 8'h03;
    localparam logic [7:0] HFDS_EP_ADDR = 8'h81;
    localparam logic [7:0] HFDS_EP_ATTR = 8'h03;
    localparam logic [15:0] HFDS_EP_MPS = 16'h0001;
    localparam logic [7:0] HFDS_EP_INTERVAL = 8'hFF;
    localparam logic [7:0] HFDS_BYTE_ZERO = 8'h00;

    // ==========================================================
    // field offsets
    localparam logic [4:0] HFDS_OFF_LEN = 5'h00;
    localparam logic [4:0] HFDS_OFF_TYPE = 5'h01;
    localparam logic [4:0] HFDS_OFF_REL_LO = 5'h02;
    localparam logic [4:0] HFDS_OFF_REL_HI = 5'h03;
    localparam logic [4:0] HFDS_OFF_CLASS = 5'h04;
    localparam logic [4:0] HFDS_OFF_SUBCLASS = 5'h05;
    localparam logic [4:0] HFDS_OFF_PROTO = 5'h06;
    localparam logic [4:0] HFDS_OFF_MPS0 = 5'h07;
    localparam logic [4:0] HFDS_OFF_VID_LO = 5'h08;
    localparam logic [4:0] HFDS_OFF_VID_HI = 5'h09;
    localparam logic [4:0] HFDS_OFF_PID_LO = 5'h0A;
    localparam logic [4:0] HFDS_OFF_PID_HI = 5'h0B;
    localparam logic [4:0] HFDS_OFF_DREL_LO = 5'h0C;
    localparam logic [4:0] HFDS_OFF_DREL_HI = 5'h0D;
    localparam logic [4:0] HFDS_OFF_MANUF = 5'h0E;
    localparam logic [4:0] HFDS_OFF_PROD = 5'h0F;
    localparam logic [4:0] HFDS_OFF_SERIAL = 5'h10;
    localparam logic [4:0] HFDS_OFF_DEV_NCFG = 5'h11;
    localparam logic [4:0] HFDS_OFF_QU_NCFG = 5'h08;
    localparam logic [4:0] HFDS_OFF_QU_RSV = 5'h09;
    localparam logic [4:0] HFDS_OFF_IF_NUM = 5'h02;
    localparam logic [4:0] HFDS_OFF_IF_ALT = 5'h03;
    localparam logic [4:0] HFDS_OFF_IF_NEP = 5'h04;
    localparam logic [4:0] HFDS_OFF_IF_CLASS = 5'h05;
    localparam logic [4:0] HFDS_OFF_IF_SUB = 5'h06;
    localparam logic [4:0] HFDS_OFF_IF_PROTO = 5'h07;
    localparam logic [4:0] HFDS_OFF_IF_STR = 5'h08;
    localparam logic [4:0] HFDS_OFF_EP_ADDR = 5'h02;
    localparam logic [4:0] HFDS_OFF_EP_ATTR = 5'h03;
    localparam logic [4:0] HFDS_OFF_EP_MPS_LO = 5'h04;
    localparam logic [4:0] HFDS_OFF_EP_MPS_HI = 5'h05;
    localparam logic [4:0] HFDS_OFF_EP_IVL = 5'h06;

    // ==========================================================
    // counter values
    localparam logic [4:0] HFDS_CNT_ZERO = 5'h00;
    localparam logic [4:0] HFDS_CNT_ONE = 5'h01;
    localparam logic [4:0] HFDS_CNT_TWO = 5'h02;

    // ==========================================================
    // types
    typedef enum logic [1:0] {
        HFDS_SEL_DEV = 2'h0,
        HFDS_SEL_IF = 2'h1,
        HFDS_SEL_EP = 2'h2,
        HFDS_SEL_QUAL = 2'h3
    } hfds_sel_t;

    typedef enum logic [1:0] {
        HFDS_ST_IDLE = 2'b01,
        HFDS_ST_SEND = 2'b10
    } hfds_state_t;

    typedef struct packed {
        logic [7:0] dtype;
        logic [15:0] max_len;
    } hfds_req_t;

    typedef struct packed {
        logic [15:0] vendor_id;
        logic [15:0] product_id;
        logic [15:0] device_rel;
        logic string_en;
        logic per_port_translator;
    } hfds_cfg_t;

    typedef struct packed {
        logic [7:0] data;
        logic last;
    } hfds_beat_t;

endpackage : hfds_pkg

// *** core/hfds_desc_rom.sv ***
// byte lookup of the four served descriptors
`timescale 1ns/100ps
`default_nettype none
module hfds_desc_rom
    import hfds_pkg::*;
(
    input wire hfds_sel_t sel_i,
    input wire logic [4:0] off_i,
    input wire hfds_cfg_t cfg_i,
    output logic [7:0] data_o,
    output logic [4:0] len_o
);

    // ==========================================================
    // string indices
    logic [7:0] str_manuf;
    logic [7:0] str_prod;
    logic [7:0] str_serial;

    assign str_manuf = cfg_i.string_en ? HFDS_STR_MANUF : HFDS_STR_NONE;
    assign str_prod = cfg_i.string_en ? HFDS_STR_PROD : HFDS_STR_NONE;
    assign str_serial = cfg_i.string_en ? HFDS_STR_SERIAL : HFDS_STR_NONE;

    // ==========================================================
    // lookup; offsets past the end read zero, the caller never reaches them
    always_comb begin
        data_o = HFDS_BYTE_ZERO;
        len_o = HFDS_LEN_DEVICE;
        unique case (sel_i)
            HFDS_SEL_DEV: begin
                len_o = HFDS_LEN_DEVICE;
                case (off_i)
                    HFDS_OFF_LEN: data_o = {3'h0, HFDS_LEN_DEVICE};
                    HFDS_OFF_TYPE: data_o = HFDS_TYPE_DEVICE;
                    HFDS_OFF_REL_LO: data_o = HFDS_USB_REL[7:0];
                    HFDS_OFF_REL_HI: data_o = HFDS_USB_REL[15:8];
                    HFDS_OFF_CLASS: data_o = HFDS_CLASS_HUB;
                    HFDS_OFF_SUBCLASS: data_o = HFDS_SUBCLASS;
                    HFDS_OFF_PROTO: data_o = HFDS_PROTO_NONE;
                    HFDS_OFF_MPS0: data_o = HFDS_MPS0;
                    HFDS_OFF_VID_LO: data_o = cfg_i.vendor_id[7:0];
                    HFDS_OFF_VID_HI: data_o = cfg_i.vendor_id[15:8];
                    HFDS_OFF_PID_LO: data_o = cfg_i.product_id[7:0];
                    HFDS_OFF_PID_HI: data_o = cfg_i.product_id[15:8];
                    HFDS_OFF_DREL_LO: data_o = cfg_i.device_rel[7:0];
                    HFDS_OFF_DREL_HI: data_o = cfg_i.device_rel[15:8];
                    HFDS_OFF_MANUF: data_o = str_manuf;
                    HFDS_OFF_PROD: data_o = str_prod;
                    HFDS_OFF_SERIAL: data_o = str_serial;
                    HFDS_OFF_DEV_NCFG: data_o = HFDS_NUM_CFG;
                    default: data_o = HFDS_BYTE_ZERO;
                endcase
            end
            HFDS_SEL_QUAL: begin
                len_o = HFDS_LEN_QUAL;
                case (off_i)
                    HFDS_OFF_LEN: data_o = {3'h0, HFDS_LEN_QUAL};
                    HFDS_OFF_TYPE: data_o = HFDS_TYPE_QUAL;
                    HFDS_OFF_REL_LO: data_o = HFDS_USB_REL[7:0];
                    HFDS_OFF_REL_HI: data_o = HFDS_USB_REL[15:8];
                    HFDS_OFF_CLASS: data_o = HFDS_CLASS_HUB;
                    HFDS_OFF_SUBCLASS: data_o = HFDS_SUBCLASS;
                    HFDS_OFF_PROTO: data_o = cfg_i.per_port_translator ?
                        HFDS_PROTO_PER_PORT : HFDS_PROTO_ONE_TT;
                    HFDS_OFF_MPS0: data_o = HFDS_MPS0;
                    HFDS_OFF_QU_NCFG: data_o = HFDS_NUM_CFG;
                    HFDS_OFF_QU_RSV: data_o = HFDS_RESERVED;
                    default: data_o = HFDS_BYTE_ZERO;
                endcase
            end
            HFDS_SEL_IF: begin
                len_o = HFDS_LEN_IFACE;
                case (off_i)
                    HFDS_OFF_LEN: data_o = {3'h0, HFDS_LEN_IFACE};
                    HFDS_OFF_TYPE: data_o = HFDS_TYPE_IFACE;
                    HFDS_OFF_IF_NUM: data_o = HFDS_IF_NUM;
                    HFDS_OFF_IF_ALT: data_o = HFDS_IF_ALT;
                    HFDS_OFF_IF_NEP: data_o = HFDS_IF_NUM_EP;
                    HFDS_OFF_IF_CLASS: data_o = HFDS_CLASS_HUB;
                    HFDS_OFF_IF_SUB: data_o = HFDS_SUBCLASS;
                    HFDS_OFF_IF_PROTO: data_o = HFDS_PROTO_NONE;
                    HFDS_OFF_IF_STR: data_o = HFDS_STR_NONE;
                    default: data_o = HFDS_BYTE_ZERO;
                endcase
            end
            HFDS_SEL_EP: begin
                len_o = HFDS_LEN_ENDPT;
                case (off_i)
                    HFDS_OFF_LEN: data_o = {3'h0, HFDS_LEN_ENDPT};
                    HFDS_OFF_TYPE: data_o = HFDS_TYPE_ENDPT;
                    HFDS_OFF_EP_ADDR: data_o = HFDS_EP_ADDR;
                    HFDS_OFF_EP_ATTR: data_o = HFDS_EP_ATTR;
                    HFDS_OFF_EP_MPS_LO: data_o = HFDS_EP_MPS[7:0];
                    HFDS_OFF_EP_MPS_HI: data_o = HFDS_EP_MPS[15:8];
                    HFDS_OFF_EP_IVL: data_o = HFDS_EP_INTERVAL;
                    default: data_o = HFDS_BYTE_ZERO;
                endcase
            end
        endcase
    end

endmodule : hfds_desc_rom
`default_nettype wire

// *** core/hfds_source.sv ***
// streaming descriptor source of the hub function at full speed
`timescale 1ns/100ps
`default_nettype none
module hfds_source
    import hfds_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic req_valid_i,
    input wire hfds_req_t req_i,
    output logic req_ready_o,
    output logic req_err_o,
    input wire hfds_cfg_t cfg_i,
    output logic byte_valid_o,
    output hfds_beat_t beat_o,
    input wire logic byte_ready_i
);

    // ==========================================================
    // request decode
    hfds_sel_t req_sel;
    logic req_known;
    logic [4:0] req_n;
    hfds_sel_t fetch_sel;
    logic [4:0] fetch_off;
    logic [7:0] rom_data;
    logic [4:0] rom_len;

    // only the full-speed view of the hub is held here
    always_comb begin
        req_sel = HFDS_SEL_DEV;
        req_known = 1'b1;
        unique case (req_i.dtype)
            HFDS_TYPE_DEVICE: req_sel = HFDS_SEL_DEV;
            HFDS_TYPE_QUAL: req_sel = HFDS_SEL_QUAL;
            HFDS_TYPE_IFACE: req_sel = HFDS_SEL_IF;
            HFDS_TYPE_ENDPT: req_sel = HFDS_SEL_EP;
            default: req_known = 1'b0;
        endcase
    end

    // a host asking for fewer bytes than the descriptor holds gets a prefix
    assign req_n = (req_i.max_len < {11'h000, rom_len}) ? req_i.max_len[4:0] : rom_len;

    hfds_desc_rom u_rom (
        .sel_i(fetch_sel),
        .off_i(fetch_off),
        .cfg_i(cfg_i),
        .data_o(rom_data),
        .len_o(rom_len)
    );

    // ==========================================================
    // stream state
    hfds_state_t state_q;
    hfds_state_t state_d;
    hfds_sel_t sel_q;
    hfds_sel_t sel_d;
    logic [4:0] off_q;
    logic [4:0] off_d;
    logic [4:0] remain_q;
    logic [4:0] remain_d;
    hfds_beat_t beat_q;
    hfds_beat_t beat_d;
    logic valid_q;
    logic valid_d;
    logic err_q;
    logic err_d;

    always_comb begin
        state_d = state_q;
        sel_d = sel_q;
        off_d = off_q;
        remain_d = remain_q;
        beat_d = beat_q;
        valid_d = valid_q;
        err_d = 1'b0;
        fetch_sel = sel_q;
        fetch_off = off_q + HFDS_CNT_ONE;
        unique case (state_q)
            HFDS_ST_IDLE: begin
                fetch_sel = req_sel;
                fetch_off = HFDS_OFF_LEN;
                if (req_valid_i) begin
                    if (!req_known) begin
                        err_d = 1'b1;
                    end else if (req_n != HFDS_CNT_ZERO) begin
                        sel_d = req_sel;
                        off_d = HFDS_OFF_LEN;
                        remain_d = req_n;
                        beat_d.data = rom_data;
                        beat_d.last = (req_n == HFDS_CNT_ONE);
                        valid_d = 1'b1;
                        state_d = HFDS_ST_SEND;
                    end
                end
            end
            HFDS_ST_SEND: begin
                if (byte_ready_i) begin
                    if (beat_q.last) begin
                        valid_d = 1'b0;
                        state_d = HFDS_ST_IDLE;
                    end else begin
                        off_d = off_q + HFDS_CNT_ONE;
                        remain_d = remain_q - HFDS_CNT_ONE;
                        beat_d.data = rom_data;
                        beat_d.last = (remain_q == HFDS_CNT_TWO);
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= HFDS_ST_IDLE;
            sel_q <= HFDS_SEL_DEV;
            off_q <= HFDS_CNT_ZERO;
            remain_q <= HFDS_CNT_ZERO;
            beat_q <= '0;
            valid_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            state_q <= state_d;
            sel_q <= sel_d;
            off_q <= off_d;
            remain_q <= remain_d;
            beat_q <= beat_d;
            valid_q <= valid_d;
            err_q <= err_d;
        end
    end

    // ==========================================================
    // outputs
    assign req_ready_o = (state_q == HFDS_ST_IDLE);
    assign req_err_o = err_q;
    assign byte_valid_o = valid_q;
    assign beat_o = beat_q;

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    logic beat_now;
    assign beat_now = valid_q;

    a_iface_header: assert property (
        beat_now && sel_q == HFDS_SEL_IF && off_q == HFDS_OFF_LEN
        |-> beat_q.data == 8'h09)
        else $error("interface length byte wrong");

    a_iface_class: assert property (
        beat_now && sel_q == HFDS_SEL_IF && off_q == HFDS_OFF_IF_CLASS
        |-> beat_q.data == 8'h09)
        else $error("interface class byte wrong");

    a_iface_number: assert property (
        beat_now && sel_q == HFDS_SEL_IF
        && (off_q == HFDS_OFF_IF_NUM || off_q == HFDS_OFF_IF_ALT)
        |-> beat_q.data == 8'h00)
        else $error("interface number or alternate not zero");

    a_iface_endpoints: assert property (
        beat_now && sel_q == HFDS_SEL_IF && off_q == HFDS_OFF_IF_NEP
        |-> beat_q.data == 8'h01)
        else $error("interface endpoint count wrong");

    a_iface_string: assert property (
        beat_now && sel_q == HFDS_SEL_IF && off_q == HFDS_OFF_IF_STR
        |-> beat_q.data == 8'h00 && beat_q.last)
        else $error("interface string byte wrong or not last");

    a_endpt_type: assert property (
        beat_now && sel_q == HFDS_SEL_EP && off_q == HFDS_OFF_TYPE
        |-> beat_q.data == 8'h05)
        else $error("endpoint type byte wrong");

    a_endpt_addr: assert property (
        beat_now && sel_q == HFDS_SEL_EP && off_q == HFDS_OFF_EP_ADDR
        |-> beat_q.data == 8'h81)
        else $error("endpoint address wrong");

    a_endpt_attr: assert property (
        beat_now && sel_q == HFDS_SEL_EP && off_q == HFDS_OFF_EP_ATTR
        |-> beat_q.data == 8'h03)
        else $error("endpoint attributes wrong");

    a_endpt_mps: assert property (
        beat_now && byte_ready_i && !beat_q.last
        && sel_q == HFDS_SEL_EP && off_q == HFDS_OFF_EP_MPS_LO
        |-> beat_q.data == 8'h01 ##1 beat_q.data == 8'h00)
        else $error("endpoint packet size wrong");

    a_endpt_interval: assert property (
        beat_now && sel_q == HFDS_SEL_EP && off_q == HFDS_OFF_EP_IVL
        |-> beat_q.data == 8'hFF && beat_q.last)
        else $error("endpoint interval wrong");

    a_dev_release: assert property (
        beat_now && byte_ready_i && !beat_q.last
        && sel_q == HFDS_SEL_DEV && off_q == HFDS_OFF_REL_LO
        |-> beat_q.data == 8'h00 ##1 beat_q.data == 8'h02)
        else $error("device release bytes wrong");

    a_dev_vendor: assert property (
        beat_now && sel_q == HFDS_SEL_DEV && off_q == HFDS_OFF_VID_HI
        |-> beat_q.data == $past(cfg_i.vendor_id[15:8]))
        else $error("vendor high byte does not follow customer value");

    a_dev_strings: assert property (
        beat_now && sel_q == HFDS_SEL_DEV && off_q == HFDS_OFF_SERIAL
        |-> beat_q.data == ($past(cfg_i.string_en) ? 8'h03 : 8'h00))
        else $error("serial string index wrong");

    a_qual_proto: assert property (
        beat_now && sel_q == HFDS_SEL_QUAL && off_q == HFDS_OFF_PROTO
        |-> beat_q.data == ($past(cfg_i.per_port_translator) ? 8'h02 : 8'h01))
        else $error("qualifier protocol wrong");

    a_offset_order: assert property (
        beat_now && byte_ready_i && !beat_q.last
        |=> beat_now && off_q == $past(off_q) + 5'h01)
        else $error("offset did not advance by one");

    a_stall_hold: assert property (
        beat_now && !byte_ready_i |=> $stable(beat_q) && beat_now)
        else $error("beat changed while stalled");

    a_start_len: assert property (
        req_valid_i && req_ready_o && req_known && req_n != 5'h00
        |=> beat_now && off_q == 5'h00 && beat_q.data == {3'h0, $past(rom_len)})
        else $error("stream did not open with the length byte");

    a_dev_type: assert property (
        beat_now && sel_q == HFDS_SEL_DEV && off_q == HFDS_OFF_TYPE
        |-> beat_q.data == 8'h01)
        else $error("device type byte wrong");

    a_dev_class: assert property (
        beat_now && sel_q == HFDS_SEL_DEV && off_q == HFDS_OFF_CLASS
        |-> beat_q.data == 8'h09)
        else $error("device class byte wrong");

    a_dev_proto: assert property (
        beat_now && sel_q == HFDS_SEL_DEV
        && (off_q == HFDS_OFF_SUBCLASS || off_q == HFDS_OFF_PROTO)
        |-> beat_q.data == 8'h00)
        else $error("device subclass or protocol not zero");

    a_ctrl_mps: assert property (
        beat_now && (sel_q == HFDS_SEL_DEV || sel_q == HFDS_SEL_QUAL)
        && off_q == HFDS_OFF_MPS0
        |-> beat_q.data == 8'h40)
        else $error("control packet size wrong");

    a_num_config: assert property (
        beat_now && ((sel_q == HFDS_SEL_DEV && off_q == HFDS_OFF_DEV_NCFG)
        || (sel_q == HFDS_SEL_QUAL && off_q == HFDS_OFF_QU_NCFG))
        |-> beat_q.data == 8'h01)
        else $error("configuration count wrong");

    a_qual_type: assert property (
        beat_now && sel_q == HFDS_SEL_QUAL && off_q == HFDS_OFF_TYPE
        |-> beat_q.data == 8'h06)
        else $error("qualifier type byte wrong");

    a_qual_reserved: assert property (
        beat_now && sel_q == HFDS_SEL_QUAL && off_q == HFDS_OFF_QU_RSV
        |-> beat_q.data == 8'h00 && beat_q.last)
        else $error("qualifier reserved byte wrong or not last");

    // a refused type must never open a stream, only raise the error pulse
    a_err_no_beat: assert property (
        req_valid_i && req_ready_o && !req_known
        |=> req_err_o && !beat_now)
        else $error("refused request opened a stream or gave no error");

    c_device_full: cover property (
        beat_now && byte_ready_i && beat_q.last && sel_q == HFDS_SEL_DEV
        && off_q == HFDS_OFF_DEV_NCFG);
    c_qual_full: cover property (
        beat_now && beat_q.last && sel_q == HFDS_SEL_QUAL && off_q == HFDS_OFF_QU_RSV);
    c_truncated: cover property (
        beat_now && beat_q.last && sel_q == HFDS_SEL_DEV && off_q == HFDS_OFF_MPS0);
    c_stalled: cover property (beat_now && !byte_ready_i ##1 beat_now && byte_ready_i);
    c_refused: cover property (req_err_o);

endmodule : hfds_source
`default_nettype wire

// *** verif/hfds_host_model.sv ***
// host-side sink model that takes descriptor bytes with random stalls
`timescale 1ns/100ps
`default_nettype none
module hfds_host_model
    import hfds_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic byte_valid_i,
    input wire hfds_beat_t beat_i,
    output logic byte_ready_o
);
    // ==========================================================
    // accepted beats in arrival order
    hfds_beat_t got[$];

    // stalls about a quarter of the cycles so held beats get exercised
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            byte_ready_o <= 1'b0;
        end else begin
            byte_ready_o <= ($urandom_range(3, 0) != 0);
            if (byte_valid_i === 1'b1 && byte_ready_o === 1'b1) begin
                got.push_back(beat_i);
            end
        end
    end
endmodule : hfds_host_model
`default_nettype wire

// *** verif/hub_fullspeed_descriptor_source_tb_top.sv ***
// self-checking bench of the descriptor source against a byte model
`timescale 1ns/100ps
`default_nettype none
module hub_fullspeed_descriptor_source_tb_top
    import hfds_pkg::*;
;
    logic clk_i;
    logic rst_i;
    logic req_valid_i;
    hfds_req_t req_i;
    logic req_ready_o;
    logic req_err_o;
    hfds_cfg_t cfg_i;
    logic byte_valid_o;
    hfds_beat_t beat_o;
    logic byte_ready_i;
    int mismatches = 0;
    int n_tests = 0;
    int errs = 0;
    int cycles = 0;
    logic st_q = 1'b0;
    hfds_beat_t pb;

    hfds_source dut (.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i), .req_i(req_i),
        .req_ready_o(req_ready_o), .req_err_o(req_err_o), .cfg_i(cfg_i),
        .byte_valid_o(byte_valid_o), .beat_o(beat_o), .byte_ready_i(byte_ready_i));
    hfds_host_model host (.clk_i(clk_i), .rst_i(rst_i), .byte_valid_i(byte_valid_o),
        .beat_i(beat_o), .byte_ready_o(byte_ready_i));

    always #2 clk_i = ~clk_i;

    task automatic final_report();
        if (mismatches == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report

    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : cmp

    function automatic int dlen(input logic [7:0] t);
        case (t)
            8'h01: return 18;
            8'h04: return 9;
            8'h05: return 7;
            8'h06: return 10;
            default: return 0;
        endcase
    endfunction : dlen

    // ==========================================================
    // expected byte at offset i, offset 0 held in the top byte
    function automatic logic [7:0] expb(input logic [7:0] t, input int i);
        logic [7:0] s;
        logic [143:0] v;
        s = {7'h00, cfg_i.string_en};
        v = '0;
        case (t)
            8'h01: v = {8'h12, 8'h01, 8'h00, 8'h02, 8'h09, 8'h00,
                8'h00, 8'h40,
                cfg_i.vendor_id[7:0], cfg_i.vendor_id[15:8], cfg_i.product_id[7:0],
                cfg_i.product_id[15:8], cfg_i.device_rel[7:0], cfg_i.device_rel[15:8],
                s, s * 8'h02, s * 8'h03, 8'h01};
            8'h04: v = 144'({8'h09, 8'h04, 8'h00, 8'h00, 8'h01,
                8'h09, 8'h00, 8'h00, 8'h00});
            8'h05: v = 144'({8'h07, 8'h05, 8'h81, 8'h03,
                8'h01, 8'h00, 8'hFF});
            8'h06: v = 144'({8'h0A, 8'h06, 8'h00, 8'h02, 8'h09, 8'h00,
                cfg_i.per_port_translator ? 8'h02 : 8'h01,
                8'h40, 8'h01, 8'h00});
            default: v = '0;
        endcase
        v = v << (8 * (18 - dlen(t)));
        return v[143 - 8 * i -: 8];
    endfunction : expb

    task automatic do_req(input logic [7:0] t, input logic [15:0] ml);
        int n;
        int k;
        n = (ml < dlen(t)) ? int'(ml) : dlen(t);
        host.got.delete();
        errs = 0;
        req_valid_i <= 1'b1;
        req_i <= '{dtype: t, max_len: ml};
        @(negedge clk_i);
        while (req_ready_o !== 1'b1) @(negedge clk_i);
        @(posedge clk_i);
        req_valid_i <= 1'b0;
        k = 0;
        while (host.got.size() < n && k < 300) begin
            @(posedge clk_i);
            k++;
        end
        repeat (3) @(posedge clk_i);
        cmp("byte count", 16'(n), 16'(host.got.size()));
        cmp("error pulse", 16'(dlen(t) == 0), 16'(errs));
        for (int i = 0; i < host.got.size() && i < n; i++) begin
            cmp("data", {8'h00, expb(t, i)}, {8'h00, host.got[i].data});
            cmp("last", 16'(i == n - 1), {15'h0000, host.got[i].last});
        end
    endtask : do_req

    // a beat offered but not taken must stand unchanged in the next cycle
    always @(posedge clk_i) begin
        if (st_q) begin
            cmp("held beat", {6'h00, 1'b1, pb}, {6'h00, byte_valid_o, beat_o});
        end
        st_q <= (byte_valid_o === 1'b1 && byte_ready_i === 1'b0 && rst_i === 1'b0);
        pb <= beat_o;
        if (req_err_o === 1'b1) begin
            errs++;
        end
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            final_report();
        end
    end

    initial begin
        logic [7:0] tl[4];
        logic [7:0] bad[5];
        logic [15:0] ml;
        tl = '{8'h01, 8'h04, 8'h05, 8'h06};
        bad = '{8'h00, 8'h02, 8'h03, 8'h07, 8'hFF};
        clk_i = 1'b0;
        rst_i = 1'b1;
        req_valid_i = 1'b0;
        req_i = '0;
        cfg_i = '0;
        void'($urandom(3));
        @(negedge clk_i);
        cmp("reset ready", 16'h0001, {15'h0000, req_ready_o});
        cmp("reset valid", 16'h0000, {15'h0000, byte_valid_o});
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int r = 0; r < 12; r++) begin
            for (int j = 0; j < 4; j++) begin
                cfg_i <= {16'($urandom), 16'($urandom), 16'($urandom),
                    r[0], r[1]};
                ml = (r < 4) ? 16'h0040 : ((r == 4) ? 16'hFFFF : 16'($urandom_range(12, 0)));
                @(posedge clk_i);
                do_req(tl[j], ml);
            end
        end
        foreach (bad[b]) begin
            do_req(bad[b], 16'h0040);
        end
        do_req(8'($urandom_range(255, 7)), 16'h0012);
        final_report();
    end
endmodule : hub_fullspeed_descriptor_source_tb_top
`default_nettype wire
